// *** rcs_clk_select.sv ***
`timescale 1ns/1ps
module rcs_clk_select (
   input  wire logic CLOCK,
   input  wire logic RESET,
   rcs_ctl_if.sel    ctl
);
   logic [31:0]       idle, next_idle;
   logic              last, next_seen;
   rcs_pkg::rcs_ref_t next_ref;

   // Presence is judged from edges, so a stuck pin reads as absent
   always_comb begin
      next_idle = idle + 32'h0000_0001;
      next_seen = ctl.ext32_seen;
      if (ctl.ext32_lvl && !last) begin
         next_idle = 32'h0000_0000;
         next_seen = 1'b1;
      end else if (idle >= 32'(rcs_pkg::EXT32_LOSS_CYC)) begin
         next_idle = idle;
         next_seen = 1'b0;
      end
      if (!ctl.low_power) begin
         next_ref = rcs_pkg::REF_EXTERNAL;
      end else if (ctl.sleep_sel && next_seen) begin
         next_ref = rcs_pkg::REF_SLEEP32;
      end else begin
         next_ref = rcs_pkg::REF_WATCHDOG;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         idle           <= 32'h0000_0000;
         last           <= 1'b0;
         ctl.ext32_seen <= 1'b0;
         ctl.ref_sel    <= rcs_pkg::REF_EXTERNAL;
      end else begin
         idle           <= next_idle;
         last           <= ctl.ext32_lvl;
         ctl.ext32_seen <= next_seen;
         ctl.ref_sel    <= next_ref;
      end
   end

   chk_active_ref: assert property (@(posedge CLOCK) disable iff (RESET)
      !ctl.low_power |=> ctl.ref_sel == rcs_pkg::REF_EXTERNAL)
      else $error("Active mode not on external reference");
   chk_sleep_wdog: assert property (@(posedge CLOCK) disable iff (RESET)
      ctl.low_power && !ctl.sleep_sel |=>
         ctl.ref_sel == rcs_pkg::REF_WATCHDOG)
      else $error("Low power not on watchdog");
   chk_sleep_ext32: assert property (@(posedge CLOCK) disable iff (RESET)
      ctl.ref_sel == rcs_pkg::REF_SLEEP32 |-> ctl.ext32_seen
         && $past(ctl.sleep_sel) && $past(ctl.low_power))
      else $error("32 kHz source used without selection");
endmodule

// *** rcs_ctl_if.sv ***
`timescale 1ns/1ps
interface rcs_ctl_if;
   logic            clk_req;
   logic [4:0]      ext_ms;
   logic            fw_run;
   logic            acc250;
   logic            radio_ok;
   logic            low_power;
   logic            sleep_sel;
   logic            ext32_lvl;
   logic            ext32_seen;
   rcs_pkg::rcs_ref_t ref_sel;
   modport seq (input clk_req, ext_ms, output fw_run, acc250, radio_ok);
   modport sel (input low_power, sleep_sel, ext32_lvl,
                output ext32_seen, ref_sel);
endinterface

// *** rcs_pkg.sv ***
// Contract
// - Internal clocks come from a PLL on external reference or 1 kHz watchdog.
// - Low-power modes run from the watchdog clock instead of the reference.
// - Reference setting is in kHz; any 250 kHz multiple is supported. Code accepts 250 kHz multiples from 8000 to 40000 kHz only.
// - Listed phone oscillator frequencies are also accepted, given in kHz.
// - After clock request rises, wait 5 ms before firmware runs.
// - Start-up extension is 1 to 31 ms; zero keeps plain 5 ms.
// - Nonzero extension prolongs start-up by that time before firmware runs.
// - Radio may start 6 ms after firmware start; reference then 20 ppm.
// - External 32 kHz clock on analogue input replaces watchdog when selected.
// - Extra power saving only when external 32 kHz clock is accurate.
// - Six-bit trim code adds 125 fF per step, range 0 to 63.
// - Clock request pin low in deep sleep, high when clock needed.
package rcs_pkg;
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_REF_FREQ = 8'h04;
   localparam logic [7:0]  ADDR_STARTUP  = 8'h08;
   localparam logic [7:0]  ADDR_TRIM     = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS   = 8'h10;
   localparam int          CTRL_PIN_EN   = 0;
   localparam int          CTRL_SLEEP_EX = 1;
   localparam int          CTRL_LOW_PWR  = 2;
   localparam int          CTRL_CLK_REQ  = 3;
   localparam int          CTRL_EX_ACC   = 4;
   localparam int          CTRL_PSAVE    = 5;
   localparam int          CTRL_W        = 6;
   localparam logic [5:0]  CTRL_RST      = 6'h00;
   localparam logic [15:0] REF_FREQ_RST  = 16'h6590;
   localparam logic [4:0]  EXT_RST       = 5'h00;
   localparam logic [5:0]  TRIM_RST      = 6'h20;
   localparam logic [12:0] TRIM_STEP_FF  = 13'h007D;
   localparam logic [15:0] FREQ_STEP_KHZ = 16'h00FA;
   localparam logic [15:0] FREQ_MIN_KHZ  = 16'h1F40;
   localparam logic [15:0] FREQ_MAX_KHZ  = 16'h9C40;
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          MS_NS         = 1000000;
   localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
   localparam logic [4:0]  BASE_MS       = 5'h05;
   localparam logic [4:0]  ACC250_MS     = 5'h02;
   localparam logic [4:0]  RADIO_MS      = 5'h06;
   localparam int          EXT32_LOSS_NS = 100000;
   localparam int          EXT32_LOSS_CYC = EXT32_LOSS_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      REF_EXTERNAL,
      REF_WATCHDOG,
      REF_SLEEP32
   } rcs_ref_t;
endpackage

// *** rcs_ref_clock_ctrl.sv ***
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rcs_ref_clock_ctrl #(
   parameter int TICK_CYCLES = rcs_pkg::CYC_PER_MS
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        ANALOGUE_IO_0,
   output logic             CLOCK_REQUEST_OUT,
   output logic             CLOCK_REQUEST_OE,
   output logic             FIRMWARE_RUN,
   output logic             RADIO_ENABLE,
   output logic [1:0]       PLL_REF_SELECT,
   output logic [15:0]      REF_FREQ_KHZ,
   output logic [5:0]       CRYSTAL_TRIM_CODE,
   output logic [12:0]      TRIM_CAP_FF,
   output logic             POWER_SAVE_EN
);
   rcs_ctl_if ctl ();

   logic [5:0]  ctrl, next_ctrl;
   logic [15:0] freq, next_freq;
   logic [4:0]  ext, next_ext;
   logic [5:0]  trim, next_trim;
   logic        freq_ok, next_freq_ok;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   logic        next_pin_out, next_pin_oe, next_psave;
   logic [12:0] next_cap;
   logic        sync1, sync2;
   logic        wr;

   // 250 kHz multiples in range, or one of the phone oscillator rates
   function automatic logic freq_supported(input logic [15:0] f);
      logic in_list;
      in_list = (f == 16'h3840) || (f == 16'h3C00) || (f == 16'h3F48)
             || (f == 16'h41A0) || (f == 16'h4B00) || (f == 16'h4BF0)
             || (f == 16'h4CE0) || (f == 16'h4D58) || (f == 16'h9600);
      return in_list || ((f % rcs_pkg::FREQ_STEP_KHZ) == 16'h0000
             && f >= rcs_pkg::FREQ_MIN_KHZ
             && f <= rcs_pkg::FREQ_MAX_KHZ);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == rcs_pkg::ADDR_CTRL || a == rcs_pkg::ADDR_REF_FREQ
          || a == rcs_pkg::ADDR_STARTUP || a == rcs_pkg::ADDR_TRIM
          || a == rcs_pkg::ADDR_STATUS;
   endfunction

   assign wr = PSEL && PENABLE && PREADY && PWRITE;

   // Sleep clock pin is asynchronous
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= ANALOGUE_IO_0;
         sync2 <= sync1;
      end
   end

   assign ctl.clk_req   = ctrl[rcs_pkg::CTRL_CLK_REQ];
   assign ctl.ext_ms    = ext;
   assign ctl.low_power = ctrl[rcs_pkg::CTRL_LOW_PWR];
   assign ctl.sleep_sel = ctrl[rcs_pkg::CTRL_SLEEP_EX];
   assign ctl.ext32_lvl = sync2;

   rcs_startup_seq #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_seq (
      .CLOCK (CLOCK),
      .RESET (RESET),
      .ctl   (ctl.seq)
   );

   rcs_clk_select u_sel (
      .CLOCK (CLOCK),
      .RESET (RESET),
      .ctl   (ctl.sel)
   );

   // Register file and APB answer, one wait state on every access
   always_comb begin
      next_ctrl    = ctrl;
      next_freq    = freq;
      next_ext     = ext;
      next_trim    = trim;
      next_prdata  = 32'h0000_0000;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (wr) begin
         unique case (PADDR)
            rcs_pkg::ADDR_CTRL:     next_ctrl = PWDATA[5:0];
            rcs_pkg::ADDR_REF_FREQ: next_freq = PWDATA[15:0];
            rcs_pkg::ADDR_STARTUP:  next_ext  = PWDATA[4:0];
            rcs_pkg::ADDR_TRIM:     next_trim = PWDATA[5:0];
            default: ;
         endcase
      end
      if (PSEL && PENABLE && !PREADY) begin
         next_pready  = 1'b1;
         next_pslverr = !mapped(PADDR);
         unique case (PADDR)
            rcs_pkg::ADDR_CTRL:     next_prdata = {26'h000_0000, ctrl};
            rcs_pkg::ADDR_REF_FREQ: next_prdata = {16'h0000, freq};
            rcs_pkg::ADDR_STARTUP:  next_prdata = {27'h000_0000, ext};
            rcs_pkg::ADDR_TRIM:     next_prdata = {26'h000_0000, trim};
            rcs_pkg::ADDR_STATUS: begin
               next_prdata = {24'h00_0000, ctl.clk_req, ctl.ref_sel,
                              ctl.ext32_seen, freq_ok, ctl.radio_ok,
                              ctl.acc250, ctl.fw_run};
            end
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Pin and output values
   always_comb begin
      next_freq_ok = freq_supported(freq);
      next_pin_oe  = ctrl[rcs_pkg::CTRL_PIN_EN];
      next_pin_out = ctrl[rcs_pkg::CTRL_PIN_EN]
                     && ctrl[rcs_pkg::CTRL_CLK_REQ];
      next_cap     = 13'(trim) * rcs_pkg::TRIM_STEP_FF;
      // Firmware vouches for 32 kHz accuracy; the pin only proves presence
      next_psave   = ctrl[rcs_pkg::CTRL_PSAVE] && ctrl[rcs_pkg::CTRL_EX_ACC]
                     && ctrl[rcs_pkg::CTRL_SLEEP_EX]
                     && ctl.ext32_seen;
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ctrl              <= rcs_pkg::CTRL_RST;
         freq              <= rcs_pkg::REF_FREQ_RST;
         ext               <= rcs_pkg::EXT_RST;
         trim              <= rcs_pkg::TRIM_RST;
         freq_ok           <= 1'b0;
         PRDATA            <= 32'h0000_0000;
         PREADY            <= 1'b0;
         PSLVERR           <= 1'b0;
         CLOCK_REQUEST_OUT <= 1'b0;
         CLOCK_REQUEST_OE  <= 1'b0;
         TRIM_CAP_FF       <= 13'h0000;
         POWER_SAVE_EN     <= 1'b0;
      end else begin
         ctrl              <= next_ctrl;
         freq              <= next_freq;
         ext               <= next_ext;
         trim              <= next_trim;
         freq_ok           <= next_freq_ok;
         PRDATA            <= next_prdata;
         PREADY            <= next_pready;
         PSLVERR           <= next_pslverr;
         CLOCK_REQUEST_OUT <= next_pin_out;
         CLOCK_REQUEST_OE  <= next_pin_oe;
         TRIM_CAP_FF       <= next_cap;
         POWER_SAVE_EN     <= next_psave;
      end
   end

   // These come straight from flops inside the submodules or here
   assign FIRMWARE_RUN      = ctl.fw_run;
   assign RADIO_ENABLE      = ctl.radio_ok;
   assign PLL_REF_SELECT    = ctl.ref_sel;
   assign REF_FREQ_KHZ      = freq;
   assign CRYSTAL_TRIM_CODE = trim;

   chk_pin_sleep_low: assert property (@(posedge CLOCK) disable iff (RESET)
      ctrl[rcs_pkg::CTRL_PIN_EN] && !ctrl[rcs_pkg::CTRL_CLK_REQ] |=>
         CLOCK_REQUEST_OE && !CLOCK_REQUEST_OUT)
      else $error("Clock request pin not low in deep sleep");
   chk_pin_req_high: assert property (@(posedge CLOCK) disable iff (RESET)
      ctrl[rcs_pkg::CTRL_PIN_EN] && ctrl[rcs_pkg::CTRL_CLK_REQ] |=>
         CLOCK_REQUEST_OE && CLOCK_REQUEST_OUT)
      else $error("Clock request pin not high when clock needed");
   chk_trim_cap: assert property (@(posedge CLOCK) disable iff (RESET)
      !$past(RESET) |-> TRIM_CAP_FF == 13'($past(trim)) * 13'h007D)
      else $error("Trim capacitance not 125 fF per step");
   chk_psave_gate: assert property (@(posedge CLOCK) disable iff (RESET)
      POWER_SAVE_EN |-> $past(ctrl[rcs_pkg::CTRL_EX_ACC])
         && $past(ctl.ext32_seen))
      else $error("Power saving without accurate 32 kHz clock");
   chk_freq_38m4: assert property (@(posedge CLOCK) disable iff (RESET)
      freq == 16'h9600 |=> freq_ok)
      else $error("38.4 MHz setting refused");
   chk_apb_answer: assert property (@(posedge CLOCK) disable iff (RESET)
      PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("APB answer not one wait state");

   if (TICK_CYCLES < 1) begin : g_tick_check
      $error("TICK_CYCLES must be at least one");
   end
endmodule

// *** rcs_ref_source.sv ***
`timescale 1ns/1ps
module rcs_ref_source #(
   parameter int TICK_CYCLES = 10
) (
   input  wire logic CLOCK,
   input  wire logic req_out,
   input  wire logic req_oe,
   input  wire logic fw_run,
   input  wire logic run32,
   output logic      sleep_clk,
   output int        ppm
);
   int fw_cycles = 0;
   // Pad is pulled down, so a stopped 32 kHz source reads low
   initial sleep_clk = 1'b0;
   always #15625 sleep_clk = run32 ? ~sleep_clk : 1'b0;
   // Source only settles while the request pin asks for it
   always_ff @(posedge CLOCK) begin
      if (!(req_oe && req_out) || !fw_run) begin
         fw_cycles <= 0;
      end else begin
         fw_cycles <= fw_cycles + 1;
      end
   end
   // Slowest source that still meets each accuracy milestone
   always_comb begin
      if (fw_cycles >= 6 * TICK_CYCLES - 1) begin
         ppm = 20;
      end else if (fw_cycles >= 2 * TICK_CYCLES - 1) begin
         ppm = 250;
      end else begin
         ppm = 1000;
      end
   end
endmodule

// *** rcs_startup_seq.sv ***
`timescale 1ns/1ps
module rcs_startup_seq #(
   parameter int TICK_CYCLES = rcs_pkg::CYC_PER_MS
) (
   input  wire logic CLOCK,
   input  wire logic RESET,
   rcs_ctl_if.seq    ctl
);
   typedef enum logic [1:0] {S_IDLE, S_BASE, S_EXT, S_RUN} rcs_seq_t;
   rcs_seq_t    state, next_state;
   logic [31:0] pre, next_pre;
   logic [4:0]  ms, next_ms;
   logic        tick;
   logic        next_fw, next_acc, next_radio;

   assign tick = (pre == 32'(TICK_CYCLES - 1));

   always_comb begin
      next_state = state;
      next_pre   = tick ? 32'h0000_0000 : pre + 32'h0000_0001;
      next_ms    = tick ? ms + 5'h01 : ms;
      next_fw    = 1'b0;
      next_acc   = ctl.acc250;
      next_radio = ctl.radio_ok;
      unique case (state)
         S_IDLE: begin
            next_pre = 32'h0000_0000;
            next_ms  = 5'h00;
            if (ctl.clk_req) begin
               next_state = S_BASE;
            end
         end
         S_BASE: begin
            if (tick && ms == rcs_pkg::BASE_MS - 5'h01) begin
               next_ms    = 5'h00;
               next_state = (ctl.ext_ms != 5'h00) ? S_EXT : S_RUN;
               next_fw    = (ctl.ext_ms == 5'h00);
            end
         end
         S_EXT: begin
            if (tick && ms == ctl.ext_ms - 5'h01) begin
               next_ms    = 5'h00;
               next_state = S_RUN;
               next_fw    = 1'b1;
            end
         end
         S_RUN: begin
            next_fw = 1'b1;
            if (ms == rcs_pkg::RADIO_MS) begin
               next_ms = ms;  // Saturate once radio is released
            end
            next_acc   = (next_ms >= rcs_pkg::ACC250_MS);
            next_radio = (next_ms >= rcs_pkg::RADIO_MS);
         end
      endcase
      if (!ctl.clk_req) begin
         next_state = S_IDLE;
         next_fw    = 1'b0;
         next_acc   = 1'b0;
         next_radio = 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state        <= S_IDLE;
         pre          <= 32'h0000_0000;
         ms           <= 5'h00;
         ctl.fw_run   <= 1'b0;
         ctl.acc250   <= 1'b0;
         ctl.radio_ok <= 1'b0;
      end else begin
         state        <= next_state;
         pre          <= next_pre;
         ms           <= next_ms;
         ctl.fw_run   <= next_fw;
         ctl.acc250   <= next_acc;
         ctl.radio_ok <= next_radio;
      end
   end

   // Cycles since request rose, only for checks
   logic [31:0] held;
   always_ff @(posedge CLOCK) begin
      if (RESET || !ctl.clk_req) begin
         held <= 32'h0000_0000;
      end else if (held != 32'hFFFF_FFFF) begin
         held <= held + 32'h0000_0001;
      end
   end

   chk_fw_full_delay: assert property (@(posedge CLOCK) disable iff (RESET)
      $rose(ctl.fw_run) |-> held >= 32'(TICK_CYCLES) *
         ((ctl.ext_ms == 5'h00) ? 32'(rcs_pkg::BASE_MS)
          : 32'(rcs_pkg::BASE_MS) + 32'(ctl.ext_ms)))
      else $error("Firmware released before start-up delay");
   chk_fw_drops: assert property (@(posedge CLOCK) disable iff (RESET)
      !ctl.clk_req |=> !ctl.fw_run)
      else $error("Firmware still running without clock request");
   chk_radio_order: assert property (@(posedge CLOCK) disable iff (RESET)
      ctl.radio_ok |-> ctl.acc250 && ctl.fw_run)
      else $error("Radio released out of order");
   chk_acc_after_fw: assert property (@(posedge CLOCK) disable iff (RESET)
      $rose(ctl.fw_run) |-> !ctl.acc250 [*2])
      else $error("Accuracy milestone too early");

   if (TICK_CYCLES < 1) begin : g_tick_check
      $error("TICK_CYCLES must be at least one");
   end
endmodule

// *** rcs_tb.sv ***
`timescale 1ns/1ps
module testbench;
   localparam int T = 10;
   logic        CLOCK = 1'b0;
   logic        RESET = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        run32 = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, aio, req_out, req_oe;
   logic        fw_run, radio_en, psave;
   logic [1:0]  ref_sel;
   logic [15:0] ref_khz;
   logic [5:0]  trim;
   logic [12:0] trim_ff;
   int          ppm;
   int          num_errors = 0;
   int          total_checks = 0;
   logic [15:0] freqs [16] = '{16'h3840, 16'h3C00, 16'h3F48, 16'h41A0,
      16'h4B00, 16'h4BF0, 16'h4CE0, 16'h4D58, 16'h9600, 16'h1F40,
      16'h9C40, 16'h6590, 16'h1F41, 16'h1E46, 16'h9D3A, 16'h3841};
   int          exts [2] = '{1, 31};
   int          codes [3] = '{0, 1, 63};

   always #50 CLOCK = ~CLOCK;

   rcs_ref_clock_ctrl #(.TICK_CYCLES(T)) dut (
      .CLOCK(CLOCK), .RESET(RESET), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .ANALOGUE_IO_0(aio),
      .CLOCK_REQUEST_OUT(req_out), .CLOCK_REQUEST_OE(req_oe),
      .FIRMWARE_RUN(fw_run), .RADIO_ENABLE(radio_en),
      .PLL_REF_SELECT(ref_sel), .REF_FREQ_KHZ(ref_khz),
      .CRYSTAL_TRIM_CODE(trim), .TRIM_CAP_FF(trim_ff),
      .POWER_SAVE_EN(psave));

   rcs_ref_source #(.TICK_CYCLES(T)) src (
      .CLOCK(CLOCK), .req_out(req_out), .req_oe(req_oe), .fw_run(fw_run),
      .run32(run32), .sleep_clk(aio), .ppm(ppm));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // An idle edge after each transfer keeps strobes single-assigned
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge CLOCK);
      penable <= 1'b1;
      do begin
         @(posedge CLOCK);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge CLOCK);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      // Pins fed from the written register are launched one edge later
      @(posedge CLOCK);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic wait_rise(input bit radio, input int lo, input int hi);
      int n;
      n = 0;
      while ((radio ? radio_en : fw_run) !== 1'b1 && n <= hi) begin
         @(posedge CLOCK);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h0000_0001);
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge CLOCK);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge CLOCK);
      RESET <= 1'b0;
      @(posedge CLOCK);
      rd_chk(rcs_pkg::ADDR_REF_FREQ, 32'h0000_6590);
      rd_chk(rcs_pkg::ADDR_STARTUP, 32'h0000_0000);
      rd_chk(rcs_pkg::ADDR_TRIM, 32'h0000_0020);
      chk(32'(trim_ff), 32'h0000_0FA0);
      chk(32'(ref_sel), 32'h0000_0000);
      for (int i = 0; i < 16; i++) begin
         // Junk in the upper half must be dropped
         wr(rcs_pkg::ADDR_REF_FREQ, {16'hFFFF, freqs[i]});
         rd_chk(rcs_pkg::ADDR_REF_FREQ, {16'h0000, freqs[i]});
         chk(32'(ref_khz), {16'h0000, freqs[i]});
         apb(1'b0, rcs_pkg::ADDR_STATUS, 32'h0000_0000);
         chk(32'(rd[3]), 32'(i < 12));
      end
      foreach (codes[i]) begin
         wr(rcs_pkg::ADDR_TRIM, 32'(codes[i]));
         rd_chk(rcs_pkg::ADDR_TRIM, 32'(codes[i]));
         chk(32'(trim), 32'(codes[i]));
         chk(32'(trim_ff), 32'(codes[i] * 125));
      end
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0009);
      chk(32'({req_oe, req_out}), 32'h0000_0003);
      wait_rise(1'b0, 5 * T - 1, 5 * T + 3);
      wait_rise(1'b1, 6 * T - 2, 6 * T + 1);
      chk(32'(ppm <= 20), 32'h0000_0001);
      apb(1'b0, rcs_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(32'(rd[2:0]), 32'h0000_0007);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0001);
      chk(32'({req_oe, req_out, fw_run}), 32'h0000_0004);
      // Abort part way, then the next request must wait the full delay
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0009);
      repeat (30) @(posedge CLOCK);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0001);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0009);
      wait_rise(1'b0, 5 * T - 1, 5 * T + 3);
      foreach (exts[i]) begin
         wr(rcs_pkg::ADDR_CTRL, 32'h0000_0001);
         wr(rcs_pkg::ADDR_STARTUP, 32'(exts[i]));
         rd_chk(rcs_pkg::ADDR_STARTUP, 32'(exts[i]));
         wr(rcs_pkg::ADDR_CTRL, 32'h0000_0009);
         wait_rise(1'b0, (5 + exts[i]) * T - 1, (5 + exts[i]) * T + 3);
      end
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0004);
      chk(32'(ref_sel), 32'h0000_0001);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0006);
      chk(32'(ref_sel), 32'h0000_0001);
      run32 <= 1'b1;
      repeat (700) @(posedge CLOCK);
      chk(32'(ref_sel), 32'h0000_0002);
      chk(32'(psave), 32'h0000_0000);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0036);
      chk(32'(psave), 32'h0000_0001);
      wr(rcs_pkg::ADDR_CTRL, 32'h0000_0026);
      chk(32'(psave), 32'h0000_0000);
      run32 <= 1'b0;
      repeat (1200) @(posedge CLOCK);
      chk(32'(ref_sel), 32'h0000_0001);
      tally_and_finish();
   end
endmodule
